/* src/rx_status_map.svh */
// register offsets, limits and timing counts for the receive status words
`ifndef RX_STATUS_MAP_SVH
`define RX_STATUS_MAP_SVH

`define OFF_PHASE_LOW   5'h16
`define OFF_DEJITTER    5'h17
`define OFF_LINE_SIG    5'h18
`define OFF_ALARM_ONE   5'h19
`define OFF_SPARE_RPT   5'h1A
`define OFF_IDENT       5'h1F

`define CLK_FREQ_HZ     100000000
`define LOSS_TIME_US    1000
`define LOSS_CYCLES     ((`CLK_FREQ_HZ / 1000000) * `LOSS_TIME_US)
`define ZERO_RUN_LEN    7'h7F
`define WIN_LEN         7'h7F
`define MIN_ONES        5'h10
`define EBIT_LIMIT      10'h3DD
`define BAD_SECONDS     3'h5
`define REPEAT_COUNT    3'h7
`define FIFO_DEPTH      5'h10

`endif

/* src/rx_status_pkg.sv */
// types shared by the receive status words
package rx_status_pkg;
  typedef struct packed {
    logic       frame_tick;
    logic       nfas_tick;
    logic       a_bit;
    logic       ts16_all_ones;
    logic       smf1_done;
    logic       smf2_done;
    logic       crc_fail;
    logic       mf_tick;
    logic       rai_crc;
    logic       sync_lost;
    logic       second_tick;
    logic [9:0] ebit_count;
    logic       sa_tick;
    logic       sa5;
    logic [3:0] sa6;
  } framer_evt_t;

  typedef struct packed {
    logic       clk_slow;
    logic       clk_fast;
    logic [4:0] fifo_level;
    logic       amp_low;
    logic [1:0] eq_level;
  } line_info_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
  } host_req_t;
endpackage

/* src/rx_signal_loss.sv */
// digital loss-of-signal detector on recovered bits
`timescale 1ns/1ps
`include "rx_status_map.svh"
module rx_signal_loss (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic bit_en,
  input  wire logic bit_val,
  output logic      lost
);
  logic [6:0] zeros_q, zeros_d;
  logic [6:0] win_q, win_d;
  logic [6:0] ones_q, ones_d;
  logic       lost_q, lost_d;

  always_comb begin
    zeros_d = zeros_q;
    win_d   = win_q;
    ones_d  = ones_q;
    lost_d  = lost_q;
    if (bit_en) begin
      zeros_d = bit_val ? 7'h00 : ((zeros_q == `ZERO_RUN_LEN) ? zeros_q : zeros_q + 7'h01);
      if (!lost_q && !bit_val && zeros_q == `ZERO_RUN_LEN - 7'h01)
        lost_d = 1'b1;
      if (lost_q) begin
        // window opens only on a pulse
        if (win_q == 7'h00) begin
          if (bit_val) begin
            win_d  = 7'h01;
            ones_d = 7'h01;
          end
        end else begin
          ones_d = ones_q + {6'h00, bit_val};
          win_d  = win_q + 7'h01;
          if (win_q == `WIN_LEN - 7'h01) begin
            win_d = 7'h00;
            if (ones_d >= {2'b00, `MIN_ONES})
              lost_d = 1'b0;
          end
        end
      end else begin
        win_d  = 7'h00;
        ones_d = 7'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zeros_q <= 7'h00;
      win_q   <= 7'h00;
      ones_q  <= 7'h00;
      lost_q  <= 1'b0;
    end else begin
      zeros_q <= zeros_d;
      win_q   <= win_d;
      ones_q  <= ones_d;
      lost_q  <= lost_d;
    end
  end

  assign lost = lost_q;
endmodule

/* src/rx_status_words.sv */
// receive status words read over the parallel microprocessor port
`timescale 1ns/1ps
`include "rx_status_map.svh"
module rx_status_words #(
  parameter int          LOSS_CYCLES = `LOSS_CYCLES,
  parameter logic [7:0]  PART_CODE   = 8'h5C  // arbitrary identification value
) (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire rx_status_pkg::host_req_t   host,
  output logic [7:0]                      rdata,
  input  wire logic                       bp_frame_pulse,
  input  wire logic                       receive_frame_pulse,
  input  wire logic                       eighth_tick,
  input  wire logic                       rx_bit_en,
  input  wire logic                       rx_bit,
  input  wire logic                       all_ones_criterion_select,
  input  wire rx_status_pkg::line_info_t  line_raw,
  input  wire rx_status_pkg::framer_evt_t evt,
  output logic [3:0]                      rx_phase_eighths_high
);
  import rx_status_pkg::*;

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  line_info_t  line_s1_q, line_s2_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // analog line indications come from the line interface, not this clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_s1_q <= '0;
      line_s2_q <= '0;
    end else begin
      line_s1_q <= line_raw;
      line_s2_q <= line_s1_q;
    end
  end

  // phase counter: eighth-bit steps from backplane pulse to receive pulse
  logic [11:0] phase_run_q, phase_run_d;
  logic [11:0] phase_q, phase_d;
  logic        phase_on_q, phase_on_d;

  always_comb begin
    phase_run_d = phase_run_q;
    phase_on_d  = phase_on_q;
    phase_d     = phase_q;
    if (bp_frame_pulse) begin
      phase_run_d = 12'h000;
      phase_on_d  = 1'b1;
    end else if (phase_on_q && receive_frame_pulse) begin
      phase_d    = phase_run_q;
      phase_on_d = 1'b0;
    end else if (phase_on_q && eighth_tick) begin
      phase_run_d = phase_run_q + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_run_q <= 12'h000;
      phase_q     <= 12'h000;
      phase_on_q  <= 1'b0;
    end else begin
      phase_run_q <= phase_run_d;
      phase_q     <= phase_d;
      phase_on_q  <= phase_on_d;
    end
  end

  // analog loss: amplitude must stay low a full millisecond before it counts
  logic [$clog2(LOSS_CYCLES+1)-1:0] amp_cnt_q, amp_cnt_d;
  logic                             amp_lost_q, amp_lost_d;

  always_comb begin
    amp_cnt_d  = amp_cnt_q;
    amp_lost_d = amp_lost_q;
    if (!line_s2_q.amp_low) begin
      amp_cnt_d  = '0;
      amp_lost_d = 1'b0;
    end else if (amp_cnt_q == LOSS_CYCLES[$bits(amp_cnt_q)-1:0] - 1'b1) begin
      amp_lost_d = 1'b1;
    end else begin
      amp_cnt_d = amp_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_cnt_q  <= '0;
      amp_lost_q <= 1'b0;
    end else begin
      amp_cnt_q  <= amp_cnt_d;
      amp_lost_q <= amp_lost_d;
    end
  end

  logic dig_lost;
  rx_signal_loss u_loss (
    .clk     (clk),
    .rst_n   (rst_n),
    .bit_en  (rx_bit_en),
    .bit_val (rx_bit),
    .lost    (dig_lost)
  );

  // framer alarm state
  logic       crc1_q, crc1_d, crc2_q, crc2_d;
  logic       ais16_q, ais16_d, rai_q, rai_d, rcrc_q, rcrc_d;
  logic       ais_q, ais_d;
  logic [2:0] bad_sec_q, bad_sec_d;
  logic       sec_ok_q, sec_ok_d;
  logic       ones_seen_q, ones_seen_d;

  always_comb begin
    crc1_d      = crc1_q;
    crc2_d      = crc2_q;
    ais16_d     = ais16_q;
    rai_d       = rai_q;
    rcrc_d      = rcrc_q;
    ais_d       = ais_q;
    bad_sec_d   = bad_sec_q;
    sec_ok_d    = sec_ok_q;
    ones_seen_d = ones_seen_q;
    if (evt.smf1_done)
      crc1_d = evt.crc_fail;
    if (evt.smf2_done)
      crc2_d = evt.crc_fail;
    if (evt.frame_tick)
      ais16_d = evt.ts16_all_ones;
    if (evt.nfas_tick)
      rai_d = evt.a_bit;
    if (evt.mf_tick)
      rcrc_d = evt.rai_crc;
    // a second is good only with no remote alarm and frame alignment held throughout
    if (evt.sync_lost || (evt.nfas_tick && evt.a_bit))
      sec_ok_d = 1'b0;
    if (evt.second_tick) begin
      sec_ok_d = 1'b1;
      if (sec_ok_q && !evt.sync_lost && evt.ebit_count > `EBIT_LIMIT)
        bad_sec_d = (bad_sec_q == `BAD_SECONDS) ? bad_sec_q : bad_sec_q + 3'h1;
      else
        bad_sec_d = 3'h0;
    end
    // criterion 1: all ones with frame alignment lost; criterion 0: one frame without a zero
    if (rx_bit_en && !rx_bit)
      ones_seen_d = 1'b0;
    if (evt.frame_tick) begin
      ones_seen_d = 1'b1;
      if (all_ones_criterion_select)
        ais_d = ones_seen_q && evt.sync_lost;
      else
        ais_d = ones_seen_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc1_q      <= 1'b0;
      crc2_q      <= 1'b0;
      ais16_q     <= 1'b0;
      rai_q       <= 1'b0;
      rcrc_q      <= 1'b0;
      ais_q       <= 1'b0;
      bad_sec_q   <= 3'h0;
      sec_ok_q    <= 1'b1;
      ones_seen_q <= 1'b1;
    end else begin
      crc1_q      <= crc1_d;
      crc2_q      <= crc2_d;
      ais16_q     <= ais16_d;
      rai_q       <= rai_d;
      rcrc_q      <= rcrc_d;
      ais_q       <= ais_d;
      bad_sec_q   <= bad_sec_d;
      sec_ok_q    <= sec_ok_d;
      ones_seen_q <= ones_seen_d;
    end
  end

  // Sa6 report: set from the link wins over a clear by the host read
  logic [3:0] last_nib_q, last_nib_d;
  logic [2:0] same_cnt_q, same_cnt_d;
  logic       have_nib_q, have_nib_d;
  logic       rpt_sa5_q, rpt_sa5_d;
  logic [3:0] rpt_nib_q, rpt_nib_d;
  logic       rpt_eight_q, rpt_eight_d;
  logic       rpt_chg_q, rpt_chg_d;
  logic       rpt_read;

  assign rpt_read = host.rd && host.addr == `OFF_SPARE_RPT;

  always_comb begin
    last_nib_d  = last_nib_q;
    same_cnt_d  = same_cnt_q;
    have_nib_d  = have_nib_q;
    rpt_sa5_d   = rpt_sa5_q;
    rpt_nib_d   = rpt_nib_q;
    rpt_eight_d = rpt_eight_q;
    rpt_chg_d   = rpt_chg_q;
    if (rpt_read) begin
      rpt_sa5_d   = 1'b0;
      rpt_nib_d   = 4'h0;
      rpt_eight_d = 1'b0;
      rpt_chg_d   = 1'b0;
    end
    if (evt.sa_tick) begin
      have_nib_d = 1'b1;
      last_nib_d = evt.sa6;
      if (have_nib_q && evt.sa6 != last_nib_q) begin
        rpt_chg_d  = 1'b1;
        same_cnt_d = 3'h0;
      end else if (have_nib_q && same_cnt_q != `REPEAT_COUNT) begin
        same_cnt_d = same_cnt_q + 3'h1;
        if (same_cnt_q == `REPEAT_COUNT - 3'h1) begin
          rpt_eight_d = 1'b1;
          rpt_sa5_d   = evt.sa5;
          rpt_nib_d   = evt.sa6;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_nib_q  <= 4'h0;
      same_cnt_q  <= 3'h0;
      have_nib_q  <= 1'b0;
      rpt_sa5_q   <= 1'b0;
      rpt_nib_q   <= 4'h0;
      rpt_eight_q <= 1'b0;
      rpt_chg_q   <= 1'b0;
    end else begin
      last_nib_q  <= last_nib_d;
      same_cnt_q  <= same_cnt_d;
      have_nib_q  <= have_nib_d;
      rpt_sa5_q   <= rpt_sa5_d;
      rpt_nib_q   <= rpt_nib_d;
      rpt_eight_q <= rpt_eight_d;
      rpt_chg_q   <= rpt_chg_d;
    end
  end

  // read data; writes have no target in this bank
  logic [4:0] lvl;
  logic [7:0] rdata_q, rdata_d;
  logic [3:0] high_q;
  assign lvl = line_s2_q.fifo_level;

  always_comb begin
    rdata_d = 8'h00;
    if (host.rd) begin
      unique case (host.addr)
        `OFF_PHASE_LOW: rdata_d = phase_q[7:0];
        `OFF_DEJITTER:  rdata_d = {line_s2_q.clk_slow, line_s2_q.clk_fast,
                                   lvl == 5'h00, lvl >= 5'h04,
                                   lvl >= (`FIFO_DEPTH >> 1),
                                   lvl >= `FIFO_DEPTH - 5'h04,
                                   lvl >= `FIFO_DEPTH, 1'b0};
        `OFF_LINE_SIG:  rdata_d = {line_s2_q.eq_level == 2'h2,
                                   line_s2_q.eq_level == 2'h1,
                                   line_s2_q.eq_level == 2'h0,
                                   amp_lost_q, 4'h0};
        `OFF_ALARM_ONE: rdata_d = {crc1_q, crc2_q, bad_sec_q == `BAD_SECONDS, dig_lost,
                                   ais16_q, ais_q, rai_q, rcrc_q};
        `OFF_SPARE_RPT: rdata_d = {rpt_sa5_q, rpt_nib_q, 1'b0, rpt_eight_q, rpt_chg_q};
        `OFF_IDENT:     rdata_d = PART_CODE;
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      high_q  <= 4'h0;
    end else begin
      rdata_q <= rdata_d;
      high_q  <= phase_q[11:8];
    end
  end

  assign rdata                 = rdata_q;
  assign rx_phase_eighths_high = high_q;
endmodule

/* dv/rx_status_words_properties.sv */
// assertions on the receive status word ports
`timescale 1ns/1ps
`include "rx_status_map.svh"
module rx_status_words_properties (
  input wire logic                       clk,
  input wire logic                       arst_n,
  input wire rx_status_pkg::host_req_t   host,
  input wire logic [7:0]                 rdata,
  input wire rx_status_pkg::line_info_t  line_raw,
  input wire rx_status_pkg::framer_evt_t evt
);
  import rx_status_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  line_info_t line_q;
  wire [4:0] lvl    = line_q.fifo_level;
  wire       rd_djt = host.rd && host.addr == `OFF_DEJITTER;
  wire       rd_sig = host.rd && host.addr == `OFF_LINE_SIG;
  wire       rd_rpt = host.rd && host.addr == `OFF_SPARE_RPT && !evt.sa_tick;
  wire       known  = host.addr inside {[`OFF_PHASE_LOW:`OFF_SPARE_RPT], `OFF_IDENT};
  // flags pass a two-stage sync, so they are judged only on a settled input
  always_ff @(posedge clk) line_q <= line_raw;
  sequence steady;
    $stable(line_raw)[*6];
  endsequence
  sequence rpt_twice;
    rd_rpt ##1 rd_rpt;
  endsequence
  unmapped_zero_a: assert property (host.rd && !known |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  djt_spare_a: assert property (rd_djt |=> !rdata[0])
    else $error("dejitter bit 0 set");
  sig_spare_a: assert property (rd_sig |=> rdata[3:0] == 4'h0)
    else $error("line status low nibble set");
  rpt_spare_a: assert property (rd_rpt |=> !rdata[2])
    else $error("report bit 2 set");
  rpt_clear_a: assert property (rpt_twice |=> rdata == 8'h00)
    else $error("report not cleared by read");
  clk_adjust_a: assert property (steady ##0 rd_djt |=>
    rdata[7:6] == {line_q.clk_slow, line_q.clk_fast}) else $error("clock adjust flags wrong");
  fifo_flags_a: assert property (steady ##0 rd_djt |=> rdata[5:1] ==
    {lvl == 5'h00, lvl >= 5'h04, lvl >= 5'h08, lvl >= 5'h0C, lvl >= 5'h10})
    else $error("fifo fill flags wrong");
  loop_flags_a: assert property (steady ##0 rd_sig |=> rdata[7:5] ==
    {line_q.eq_level == 2'h2, line_q.eq_level == 2'h1, line_q.eq_level == 2'h0})
    else $error("loop length flags wrong");
endmodule
bind rx_status_words rx_status_words_properties chk_inst (
  .clk(clk), .arst_n(arst_n), .host(host), .rdata(rdata), .line_raw(line_raw), .evt(evt));

/* dv/e1_line_model.sv */
// far-end terminal: recovered bit stream with a chosen ones density
`timescale 1ns/1ps
module e1_line_model (
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  output logic            bit_en,
  output logic            bit_val
);
  logic [2:0] pos_q = 3'h0;
  logic [2:0] pos_d;
  always_comb pos_d = pos_q + 3'h1;
  always_ff @(posedge clk) pos_q <= pos_d;
  // mode 0 silent, 1 zeros, 2 one pulse in eight, 3 ones; silent line toggles
  assign bit_en  = mode != 2'h0;
  assign bit_val = mode == 2'h0 ? pos_q[0] : mode == 2'h3 || (mode == 2'h2 && pos_q == 3'h0);
endmodule

/* dv/rx_status_words_tb.sv */
// self-checking bench for the receive status words
`timescale 1ns/1ps
`include "rx_status_map.svh"
module rx_status_words_tb;
  import rx_status_pkg::*;
  localparam logic [7:0] CODE = 8'hC3;  // arbitrary identification value
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        bp = 1'b0;
  logic        rxp = 1'b0;
  logic        tick = 1'b0;
  logic        sel = 1'b0;
  logic        ben;
  logic        bval;
  logic [1:0]  mode = 2'h0;
  logic [3:0]  hi;
  logic [7:0]  rdata;
  logic [7:0]  got;
  host_req_t   host = '0;
  line_info_t  line = '0;
  framer_evt_t evt = '0;
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;
  rx_status_words #(.LOSS_CYCLES(20), .PART_CODE(CODE)) rx_status_words_inst (
    .clk(clk), .arst_n(arst_n), .host(host), .rdata(rdata), .bp_frame_pulse(bp),
    .receive_frame_pulse(rxp), .eighth_tick(tick), .rx_bit_en(ben), .rx_bit(bval),
    .all_ones_criterion_select(sel), .line_raw(line), .evt(evt),
    .rx_phase_eighths_high(hi));
  e1_line_model e1_line_model_inst (.clk(clk), .mode(mode), .bit_en(ben), .bit_val(bval));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(logic [4:0] a, int n = 1);
    cyc(1);
    host = '{1'b1, 1'b0, a};
    cyc(n);
    host = '0;
    got = rdata;
  endtask
  task automatic chk(logic [7:0] e, logic [7:0] m = 8'hFF);
    checked++;
    if ((got & m) !== e) begin
      error_cnt++;
      $display("[ERR] %0t exp %h got %h", $time, e, got & m);
    end
  endtask
  task automatic probe(int n, logic [4:0] a, logic [7:0] e, logic [7:0] m);
    cyc(n);
    rd(a);
    chk(e, m);
  endtask
  task automatic pulse();
    cyc(1);
    evt = '0;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    cyc(5);
    arst_n = 1'b1;
    cyc(3);
    host = '{1'b0, 1'b1, `OFF_IDENT};
    probe(0, `OFF_IDENT, CODE, 8'hFF);
    probe(0, 5'h00, 8'h00, 8'hFF);
    for (logic [4:0] f = 5'h00; f <= 5'h10; f += 5'h04) begin
      line.fifo_level = f;
      line.clk_slow = f[2];
      line.clk_fast = f[3];
      probe(8, `OFF_DEJITTER, {f[2], f[3], f == 5'h00, f >= 5'h04, f >= 5'h08,
        f >= 5'h0C, f[4], 1'b0}, 8'hFF);
    end
    for (logic [2:0] q = 3'h0; q < 3'h4; q++) begin
      line.eq_level = q[1:0];
      probe(8, `OFF_LINE_SIG, {q == 3'h2, q == 3'h1, q == 3'h0, 5'h00}, 8'hFF);
    end
    line.amp_low = 1'b1;
    probe(10, `OFF_LINE_SIG, 8'h00, 8'h10);
    probe(30, `OFF_LINE_SIG, 8'h10, 8'h10);
    mode = 2'h1;
    probe(120, `OFF_ALARM_ONE, 8'h00, 8'h10);
    probe(10, `OFF_ALARM_ONE, 8'h10, 8'h10);
    mode = 2'h2;
    probe(60, `OFF_ALARM_ONE, 8'h10, 8'h10);
    probe(90, `OFF_ALARM_ONE, 8'h00, 8'h10);
    for (int v = 1; v >= 0; v--) begin
      evt.smf1_done = 1'b1;
      evt.crc_fail = v[0];
      pulse();
      evt.smf2_done = 1'b1;
      evt.crc_fail = !v[0];
      evt.nfas_tick = 1'b1;
      evt.a_bit = v[0];
      evt.mf_tick = 1'b1;
      evt.rai_crc = v[0];
      evt.frame_tick = 1'b1;
      evt.ts16_all_ones = v[0];
      pulse();
      probe(0, `OFF_ALARM_ONE, {v[0], !v[0], 2'h0, v[0], 1'b0, v[0], v[0]},
        8'hDB);
    end
    for (int s = 0; s < 11; s++) begin
      evt.second_tick = 1'b1;
      evt.sync_lost = s == 10;
      evt.ebit_count = s < 5 ? `EBIT_LIMIT : `EBIT_LIMIT + 10'h001;
      pulse();
      probe(0, `OFF_ALARM_ONE, s == 9 ? 8'h20 : 8'h00, 8'h20);
    end
    for (int n = 1; n <= 9; n++) begin
      evt.sa_tick = 1'b1;
      evt.sa5 = 1'b1;
      evt.sa6 = n < 9 ? 4'hA : 4'h5;
      pulse();
      probe(0, `OFF_SPARE_RPT, n == 8 ? 8'hD2 : {7'h00, n == 9},
        n == 1 ? 8'hFE : 8'hFF);
    end
    rd(`OFF_SPARE_RPT, 2);
    chk(8'h00);
    // all-ones alarm under both criteria; the first frame still holds earlier zeros
    for (int k = 0; k < 5; k++) begin
      mode = k < 4 ? 2'h3 : 2'h2;
      sel = k == 2 || k == 3;
      cyc(10);
      evt.frame_tick = 1'b1;
      evt.sync_lost = k == 3;
      pulse();
      probe(0, `OFF_ALARM_ONE, k == 1 || k == 3 ? 8'h04 : 8'h00, 8'h04);
    end
    bp = 1'b1;
    cyc(1);
    bp = 1'b0;
    tick = 1'b1;
    cyc(300);
    tick = 1'b0;
    rxp = 1'b1;
    cyc(1);
    rxp = 1'b0;
    probe(2, `OFF_PHASE_LOW, 8'h2C, 8'hFF);
    got = {4'h0, hi};
    chk(8'h01);
    finish_test();
  end
endmodule
